// File: logic/etpc_pkg.sv
`default_nettype none
package etpc_pkg;
    localparam int CNT_W = 10;
    // channel mode field codes
    localparam logic [1:0] MODE_CAP = 2'h1;
    localparam logic [1:0] MODE_OUT = 2'h2;
    // output control codes in output modes
    localparam logic [1:0] IO_LOW    = 2'h0;
    localparam logic [1:0] IO_HIGH   = 2'h1;
    localparam logic [1:0] IO_PWM    = 2'h2;
    localparam logic [1:0] IO_SINGLE = 2'h3;
    // output control codes in capture mode, and the centre alignment code
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [1:0] EDGE_NONE = 2'h3;
    localparam logic [1:0] ALIGN_CENTRE = 2'h3;
    // period code scaling
    localparam logic [10:0] PERIOD_STEP    = 11'h080;
    localparam logic [10:0] CODE_ZERO_SPAN = 11'h400;
    localparam logic [9:0]  CNT_MAX        = 10'h3FF;
    localparam logic [9:0]  CNT_ZERO       = 10'h000;

    typedef struct packed {
        logic [1:0]       chan_a_mode_field;
        logic [1:0]       chan_b_mode_field;
        logic [1:0]       chan_a_output_control;
        logic [1:0]       chan_b_output_control;
        logic [1:0]       pwm_alignment_field;
        logic             period_source_select;
        logic [2:0]       period_code;
        logic             chan_a_initial_level;
        logic             chan_b_initial_level;
        logic             chan_a_polarity_invert;
        logic             chan_b_polarity_invert;
        logic [CNT_W-1:0] chan_a_compare_value;
        logic [CNT_W-1:0] chan_b_compare_value;
    } etpc_cfg_s;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             dir_down;
        logic             run;
        logic             run_prev;
        logic             pulse_a;
        logic             pulse_b;
        logic [2:0]       sync1;
        logic [2:0]       sync2;
        logic [2:0]       prev;
        logic [CNT_W-1:0] cap_a;
        logic [CNT_W-1:0] cap_b;
        logic             pin_a;
        logic             pin_b;
        logic             oe_a;
        logic             oe_b;
        logic             irq_a;
        logic             irq_b;
        logic             irq_p;
    } etpc_state_s;

    localparam etpc_state_s ST_RST = '0;
endpackage
`default_nettype wire

// File: logic/etpc_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - edge PWM: compare A sets period, B duty
// - centre PWM: period 256 times code, duty 2C-1
// - centre PWM: period twice compare A value
// - alignment field 11 selects centre PWM
// - centre PWM: period irq at down-count zero
// - counting continues while pin forced fixed
// - run rise starts counter, channel A pulse
// - comparator B match starts channel B pulse
// - single pulse: external clock pin rise sets run bit
// - A match clears run, ends both pulses
// - single pulse: irq on A and B match
// - single pulse: reset only on run rise
// - capture mode 01 starts on run rise
// - capture edge latches counter, raises irq
// - capture: period match resets counter, irq
// - period code zero lets counter reach maximum
// - edge select 11 disables capture
// - capture sees pin even when driven
// - capture ignores source, level, polarity bits
// - duty at or above period gives full duty
// - initial level sets polarity, invert flips pin
module etpc_timer
    import etpc_pkg::*;
(
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst,
    input  wire etpc_cfg_s        i_cfg,
    input  wire logic             i_tick,
    input  wire logic             i_run_wr,
    input  wire logic             i_run_wr_val,
    input  wire logic             i_external_timer_clock_pin,
    input  wire logic             i_chan_a_pin,
    input  wire logic             i_chan_b_pin,
    output logic                  o_chan_a_pin,
    output logic                  o_chan_a_pin_oe_n,
    output logic                  o_chan_b_pin,
    output logic                  o_chan_b_pin_oe_n,
    output logic                  o_counter_run_bit,
    output logic [CNT_W-1:0]      o_count,
    output logic [CNT_W-1:0]      o_cap_a,
    output logic [CNT_W-1:0]      o_cap_b,
    output logic                  o_irq_a,
    output logic                  o_irq_b,
    output logic                  o_irq_p
);
    typedef enum logic [1:0] {OP_OTHER, OP_PWM, OP_SINGLE, OP_CAPTURE} etpc_op_e;

    etpc_state_s s;
    etpc_state_s next_s;
    etpc_op_e    op;
    logic        centre;
    logic        run_rise;
    logic        tck_rise;
    logic        a_hit;
    logic        b_hit;
    logic        step;
    logic [10:0] span;
    logic [9:0]  top_edge;
    logic [9:0]  half;

    // period span for a code, code zero meaning the full range
    function automatic logic [10:0] etpc_span(input logic [2:0] code);
        return (code == 3'h0) ? CODE_ZERO_SPAN : 11'(11'(code) * PERIOD_STEP);
    endfunction

    function automatic logic etpc_edge(input logic [1:0] sel, input logic cur,
                                       input logic old);
        case (sel)
            EDGE_RISE: return cur & ~old;
            EDGE_FALL: return ~cur & old;
            EDGE_BOTH: return cur ^ old;
            default:   return 1'b0;
        endcase
    endfunction

    // pin level from waveform, forced levels bypass the waveform
    function automatic logic etpc_pin(input logic [1:0] io, input logic wave,
                                      input logic lvl, input logic inv);
        case (io)
            IO_LOW:  return 1'b0;
            IO_HIGH: return 1'b1;
            default: return (wave ? lvl : ~lvl) ^ inv;
        endcase
    endfunction

    always_comb begin
        if (i_cfg.chan_a_mode_field == MODE_CAP && i_cfg.chan_b_mode_field == MODE_CAP) begin
            op = OP_CAPTURE;
        end else if (i_cfg.chan_a_mode_field == MODE_OUT
                     && i_cfg.chan_b_mode_field == MODE_OUT) begin
            op = (i_cfg.chan_a_output_control == IO_SINGLE
                  && i_cfg.chan_b_output_control == IO_SINGLE) ? OP_SINGLE : OP_PWM;
        end else begin
            op = OP_OTHER;
        end
    end

    assign centre   = (op == OP_PWM) && (i_cfg.pwm_alignment_field == ALIGN_CENTRE);
    assign run_rise = s.run & ~s.run_prev;
    assign tck_rise = s.sync2[2] & ~s.prev[2];
    assign a_hit    = etpc_edge(i_cfg.chan_a_output_control, s.sync2[0], s.prev[0]);
    assign b_hit    = etpc_edge(i_cfg.chan_b_output_control, s.sync2[1], s.prev[1]);
    assign step     = s.run && !run_rise && i_tick;
    assign span     = etpc_span(i_cfg.period_code);
    // edge period: code span or compare A value
    assign top_edge = i_cfg.period_source_select ? i_cfg.chan_a_compare_value - 10'h001
                                                 : 10'(span - 11'h001);
    // centre half period, code zero capped at the counter maximum
    assign half     = i_cfg.period_source_select ? i_cfg.chan_a_compare_value
                    : (span > 11'(CNT_MAX)) ? CNT_MAX : span[9:0];

    always_comb begin
        next_s          = s;
        next_s.irq_a    = 1'b0;
        next_s.irq_b    = 1'b0;
        next_s.irq_p    = 1'b0;
        next_s.sync1    = {i_external_timer_clock_pin, i_chan_b_pin, i_chan_a_pin};
        next_s.sync2    = s.sync1;
        next_s.prev     = s.sync2;
        next_s.run_prev = s.run;
        if (i_run_wr) begin
            next_s.run = i_run_wr_val;
        end
        if (run_rise) begin
            next_s.cnt      = CNT_ZERO;
            next_s.dir_down = 1'b0;
            next_s.pulse_a  = (op == OP_SINGLE);
            next_s.pulse_b  = 1'b0;
        end else if (step) begin
            case (op)
                OP_PWM: begin
                    if (!centre) begin
                        next_s.cnt   = (s.cnt == top_edge) ? CNT_ZERO : s.cnt + 10'h001;
                        next_s.irq_p = (s.cnt == top_edge) && !i_cfg.period_source_select;
                        next_s.irq_a = i_cfg.period_source_select ? (s.cnt == top_edge)
                                     : (s.cnt == i_cfg.chan_a_compare_value);
                    end else if (!s.dir_down) begin
                        next_s.dir_down = (s.cnt >= half);
                        next_s.cnt      = (s.cnt >= half) ? s.cnt - 10'h001 : s.cnt + 10'h001;
                        next_s.irq_a    = (s.cnt == i_cfg.chan_a_compare_value);
                    end else begin
                        next_s.cnt      = s.cnt - 10'h001;
                        next_s.dir_down = (s.cnt != 10'h001);
                        next_s.irq_p    = (s.cnt == 10'h001);
                        next_s.irq_a    = (s.cnt == i_cfg.chan_a_compare_value);
                    end
                    next_s.irq_b = (s.cnt == i_cfg.chan_b_compare_value);
                end
                OP_SINGLE: begin
                    next_s.cnt = s.cnt + 10'h001;
                    if (s.cnt == i_cfg.chan_b_compare_value) begin
                        next_s.pulse_b = 1'b1;
                        next_s.irq_b   = 1'b1;
                    end
                    if (s.cnt == i_cfg.chan_a_compare_value) begin
                        next_s.run   = 1'b0;
                        next_s.irq_a = 1'b1;
                    end
                end
                OP_CAPTURE: begin
                    if (i_cfg.period_code != 3'h0 && s.cnt == span[9:0]) begin
                        next_s.cnt   = CNT_ZERO;
                        next_s.irq_p = 1'b1;
                    end else begin
                        next_s.cnt = s.cnt + 10'h001;
                    end
                end
                default: begin
                    next_s.cnt = s.cnt + 10'h001;
                end
            endcase
        end
        // capture uses the synchronised pin input whoever drives it
        if (op == OP_CAPTURE) begin
            if (a_hit) begin
                next_s.cap_a = s.cnt;
                next_s.irq_a = 1'b1;
            end
            if (b_hit) begin
                next_s.cap_b = s.cnt;
                next_s.irq_b = 1'b1;
            end
        end
        if (op == OP_SINGLE && tck_rise) begin
            next_s.run = 1'b1;
        end
        // clearing run ends both pulses
        next_s.pulse_a = next_s.pulse_a & next_s.run;
        next_s.pulse_b = next_s.pulse_b & next_s.run;
        if (op == OP_SINGLE) begin
            next_s.pin_a = etpc_pin(IO_SINGLE, s.pulse_a, i_cfg.chan_a_initial_level,
                                    i_cfg.chan_a_polarity_invert);
            next_s.pin_b = etpc_pin(IO_SINGLE, s.pulse_b, i_cfg.chan_b_initial_level,
                                    i_cfg.chan_b_polarity_invert);
        end else begin
            // duty compare runs whatever the control field forces
            next_s.pin_a = etpc_pin(i_cfg.chan_a_output_control,
                                    s.cnt < i_cfg.chan_a_compare_value,
                                    i_cfg.chan_a_initial_level,
                                    i_cfg.chan_a_polarity_invert);
            next_s.pin_b = etpc_pin(i_cfg.chan_b_output_control,
                                    s.cnt < i_cfg.chan_b_compare_value,
                                    i_cfg.chan_b_initial_level,
                                    i_cfg.chan_b_polarity_invert);
        end
        // capture never drives; in PWM, A stays off when it is the period source
        next_s.oe_a = (op == OP_SINGLE)
                    || (op == OP_PWM && !i_cfg.period_source_select);
        next_s.oe_b = (op == OP_SINGLE) || (op == OP_PWM);
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            s <= ST_RST;
        end else begin
            s <= next_s;
        end
    end

    assign o_chan_a_pin      = s.pin_a;
    assign o_chan_b_pin      = s.pin_b;
    assign o_chan_a_pin_oe_n = ~s.oe_a;
    assign o_chan_b_pin_oe_n = ~s.oe_b;
    assign o_counter_run_bit = s.run;
    assign o_count           = s.cnt;
    assign o_cap_a           = s.cap_a;
    assign o_cap_b           = s.cap_b;
    assign o_irq_a           = s.irq_a;
    assign o_irq_b           = s.irq_b;
    assign o_irq_p           = s.irq_p;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    sequence s_a_match;
        op == OP_SINGLE && step && !tck_rise && s.cnt == i_cfg.chan_a_compare_value;
    endsequence
    sequence s_tck_start;
        op == OP_SINGLE && tck_rise && !s.run && !i_run_wr;
    endsequence

    property p_sp_lead;
        op == OP_SINGLE && run_rise |=> s.cnt == CNT_ZERO && (s.pulse_a || !s.run);
    endproperty
    a_sp_lead: assert property (p_sp_lead) else $error("pulse did not start");

    property p_sp_trail;
        s_a_match |=> !s.run && !s.pulse_a && !s.pulse_b && o_irq_a;
    endproperty
    a_sp_trail: assert property (p_sp_trail) else $error("pulse did not end");

    property p_sp_tck;
        s_tck_start |=> s.run ##1 (s.pulse_a || !s.run);
    endproperty
    a_sp_tck: assert property (p_sp_tck) else $error("pin edge did not start");

    property p_cap_a;
        op == OP_CAPTURE && a_hit |=> o_cap_a == $past(s.cnt) && o_irq_a;
    endproperty
    a_cap_a: assert property (p_cap_a) else $error("capture A missed");

    property p_cap_off;
        op == OP_CAPTURE && i_cfg.chan_a_output_control == EDGE_NONE |=> $stable(o_cap_a);
    endproperty
    a_cap_off: assert property (p_cap_off) else $error("capture while disabled");

    property p_hold;
        !s.run |=> $stable(s.cnt);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved while stopped");

    property p_centre_irq;
        centre && step && s.dir_down && s.cnt == 10'h001 |=> o_irq_p && s.cnt == CNT_ZERO;
    endproperty
    a_centre_irq: assert property (p_centre_irq) else $error("no period irq");

    property p_cap_wrap;
        op == OP_CAPTURE && step && i_cfg.period_code != 3'h0 && s.cnt == span[9:0]
            |=> s.cnt == CNT_ZERO && o_irq_p;
    endproperty
    a_cap_wrap: assert property (p_cap_wrap) else $error("capture period wrong");

    property p_edge_a_period;
        op == OP_PWM && !centre && i_cfg.period_source_select && step
            && s.cnt == top_edge |=> s.cnt == CNT_ZERO && o_irq_a && !o_irq_p;
    endproperty
    a_edge_a_period: assert property (p_edge_a_period) else $error("A period wrong");
endmodule // etpc_timer
`default_nettype wire

// File: verif/enhanced_timer_pwm_pulse_capture_tb.sv
`timescale 1ns/1ps
`default_nettype none
module enhanced_timer_pwm_pulse_capture_tb
    import etpc_pkg::*;
;
    logic             i_ref_clk = 1'h0;
    logic             i_rst     = 1'h1;
    etpc_cfg_s        cfg       = '0;
    etpc_cfg_s        c;
    logic             tick      = 1'h1;
    logic             run_wr    = 1'h0;
    logic             run_val   = 1'h0;
    logic [2:0]       want      = '0;
    logic [3:0]       lag       = '0;
    logic [2:0]       pin;
    logic             pa, pa_oe_n, pb, pb_oe_n, run, irq_a, irq_b, irq_p;
    logic [CNT_W-1:0] cnt, cap_a, cap_b, capv;
    logic [31:0]      seed = 32'h4649;
    logic [2:0]       codes [7] = '{3'h1, 3'h3, 3'h0, 3'h0, 3'h1, 3'h0, 3'h0};
    int               n_fail = 0;
    int               compares = 0;
    int               n, na, nb, ca, cb, per, tb, c0, seen, hits;
    logic             src, ctr;

    always #2 i_ref_clk = ~i_ref_clk;

    etpc_pin_model u_pins (.i_ref_clk(i_ref_clk), .i_want(want), .i_lag(lag), .o_pin(pin));
    etpc_timer dut (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cfg(cfg), .i_tick(tick),
        .i_run_wr(run_wr), .i_run_wr_val(run_val), .i_external_timer_clock_pin(pin[2]),
        .i_chan_a_pin(pin[0]), .i_chan_b_pin(pin[1]), .o_chan_a_pin(pa),
        .o_chan_a_pin_oe_n(pa_oe_n), .o_chan_b_pin(pb), .o_chan_b_pin_oe_n(pb_oe_n),
        .o_counter_run_bit(run), .o_count(cnt), .o_cap_a(cap_a), .o_cap_b(cap_b),
        .o_irq_a(irq_a), .o_irq_b(irq_b), .o_irq_p(irq_p));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // active level of each channel pin: initial level, then inverted
    function automatic logic act(etpc_cfg_s x, int ch);
        return ch ? x.chan_b_initial_level ^ x.chan_b_polarity_invert
                  : x.chan_a_initial_level ^ x.chan_a_polarity_invert;
    endfunction

    // both mode fields equal, random initial levels and inverts
    function automatic etpc_cfg_s mk(logic [1:0] m, logic [1:0] ia, logic [1:0] ib,
                                     logic [1:0] al, logic s, logic [2:0] code, int a, int b);
        return etpc_cfg_s'({m, m, ia, ib, al, s, code, 4'(rnd()), 10'(a), 10'(b)});
    endfunction

    task automatic chk(string what, int ev, logic [15:0] got);
        compares++;
        if (got !== 16'(ev)) begin
            n_fail++;
            $display("Error %s expected %0d seen %0d", what, ev, got);
        end
    endtask

    task automatic smp();
        @(negedge i_ref_clk);
        na += int'(pa === act(c, 0));
        nb += int'(pb === act(c, 1));
    endtask

    task automatic duty(int len);
        na = 0;
        nb = 0;
        repeat (len) smp();
    endtask

    function automatic logic irq(int k);
        return k == 0 ? irq_p : irq_a;
    endfunction

    // cycles between two successive interrupt pulses
    task automatic span(int k, output int m);
        m = 0;
        @(negedge i_ref_clk);
        for (int i = 0; i < 3000 && irq(k) !== 1'h1; i++) @(negedge i_ref_clk);
        do begin
            m++;
            @(negedge i_ref_clk);
        end while (m < 3000 && irq(k) !== 1'h1);
    endtask

    task automatic setrun(logic v);
        @(posedge i_ref_clk);
        run_wr <= 1'h1;
        run_val <= v;
        @(posedge i_ref_clk);
        run_wr <= 1'h0;
    endtask

    task automatic start(etpc_cfg_s nc);
        setrun(1'h0);
        @(posedge i_ref_clk);
        cfg <= nc;
        setrun(1'h1);
    endtask

    task automatic summarize();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #320000;
        n_fail++;
        summarize();
    end

    initial begin
        repeat (2) @(negedge i_ref_clk);
        chk("reset oe_n", 3, {pa_oe_n, pb_oe_n});
        chk("reset run count", 0, {run, cnt});
        @(posedge i_ref_clk);
        i_rst <= 1'h0;
        repeat (4) @(posedge i_ref_clk);
        // edge and centre pwm, period from code or compare a
        for (int t = 0; t < 7; t++) begin
            ctr = t > 3;
            src = t == 3 || t == 5;
            ca = 2 + rnd() % 100;
            cb = (t == 1) ? 384 : 1 + rnd() % (ca - 1);
            c = mk(MODE_OUT, IO_PWM, IO_PWM, ctr ? ALIGN_CENTRE : 2'h0, src, codes[t], ca, cb);
            per = src ? ca : (codes[t] == 0 ? 1024 : 128 * codes[t]);
            if (ctr) per = (per == 1024) ? 2046 : 2 * per;
            start(c);
            span(int'(src && !ctr), n);
            chk("period", per, n);
            duty(per);
            if (!src) chk("duty a", ctr ? 2 * ca - 1 : ca, na);
            chk("duty b", ctr ? 2 * cb - 1 : (cb > per ? per : cb), nb);
            if (src) chk("oe_n a", 1, pa_oe_n);
        end
        c = mk(MODE_OUT, IO_LOW, IO_HIGH, 2'h0, 1'h0, 3'h1, 50, 60);
        start(c);
        span(0, n);
        chk("forced period", 128, n);
        duty(128);
        chk("forced a", act(c, 0) ? 0 : 128, na);
        chk("forced b", act(c, 1) ? 128 : 0, nb);
        @(posedge i_ref_clk);
        tick <= 1'h0;
        @(negedge i_ref_clk);
        c0 = cnt;
        repeat (9) @(negedge i_ref_clk);
        chk("count held", c0, cnt);
        @(posedge i_ref_clk);
        tick <= 1'h1;
        // single pulse, compare a beyond the period code span
        ca = 130 + rnd() % 100;
        cb = 5 + rnd() % 20;
        c = mk(MODE_OUT, IO_SINGLE, IO_SINGLE, 2'h0, 1'h1, 3'h1, ca, cb);
        start(c);
        tb = 0;
        n = 0;
        na = 0;
        nb = 0;
        while (n < 600 && irq_a !== 1'h1) begin
            smp();
            n++;
            if (irq_b === 1'h1) tb = n;
        end
        repeat (4) smp();
        chk("irq b to a", ca - cb, n - tb);
        chk("width a", 1, na >= ca && na <= ca + 2);
        chk("b lead", 1, na - nb == cb || na - nb == cb + 1);
        chk("run cleared", 0, run);
        chk("pins idle", 0, pa === act(c, 0) || pb === act(c, 1));
        c0 = cnt;
        repeat (20) @(negedge i_ref_clk);
        chk("count stopped", c0, cnt);
        start(c);
        repeat (10) @(negedge i_ref_clk);
        chk("pulse a on", 1, pa === act(c, 0));
        setrun(1'h0);
        repeat (3) @(negedge i_ref_clk);
        chk("pulse a off", 0, pa === act(c, 0));
        @(posedge i_ref_clk);
        lag <= 4'(rnd() % 8);
        want[2] <= 1'h1;
        n = 0;
        while (n < 40 && run !== 1'h1) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk("pin sets run", 1, run);
        n = 0;
        while (n < 600 && irq_a !== 1'h1) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk("restart from zero", 1, n >= ca - 2 && n <= ca + 3);
        @(posedge i_ref_clk);
        want[2] <= 1'h0;
        // capture mode
        c = mk(MODE_CAP, EDGE_RISE, EDGE_NONE, 2'h0, 1'h1, 3'h1, 0, 0);
        start(c);
        span(0, n);
        chk("capture period", 129, n);
        chk("capture oe_n", 3, {pa_oe_n, pb_oe_n});
        c.period_code = 3'h0;
        hits = 0;
        for (int e = 0; e < 7; e++) begin
            c.chan_a_output_control = 2'(e / 2);
            c.chan_b_output_control = (e == 6) ? EDGE_BOTH : EDGE_NONE;
            @(posedge i_ref_clk);
            cfg <= c;
            want[1:0] <= {2{~want[0]}};
            @(negedge i_ref_clk);
            n = 0;
            while (n < 20 && pin[0] !== want[0]) begin
                @(negedge i_ref_clk);
                n++;
            end
            c0 = cnt;
            seen = 0;
            repeat (8) begin
                @(negedge i_ref_clk);
                hits += int'(irq_b === 1'h1);
                if (irq_a === 1'h1) begin
                    seen = 1;
                    capv = cap_a;
                end
            end
            chk("capture irq", e == 0 || (e > 2 && e < 6), seen);
            if (seen == 1) chk("capture value", 1, capv - c0 >= 1 && capv - c0 <= 5);
        end
        chk("capture b count", 1, hits);
        chk("capture b value", 1, cap_b - c0 >= 1 && cap_b - c0 <= 5);
        n = 0;
        while (n < 1100 && cnt !== CNT_MAX) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk("count reaches max", CNT_MAX, cnt);
        @(negedge i_ref_clk);
        chk("count wraps", 0, cnt);
        summarize();
    end
endmodule // enhanced_timer_pwm_pulse_capture_tb
`default_nettype wire

// File: verif/etpc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side circuitry: chan a, chan b and external clock pin follow
// their requests after a chosen lag, one cycle behind at 0 and up to 16 cycles behind at 15
module etpc_pin_model (
    input  wire logic       i_ref_clk,
    input  wire logic [2:0] i_want,
    input  wire logic [3:0] i_lag,
    output logic      [2:0] o_pin
);
    logic [47:0] hist = '0;
    always @(posedge i_ref_clk) begin
        hist <= {hist[44:0], i_want};
    end
    assign o_pin = hist[6'(i_lag) * 6'h3 +: 3];
endmodule // etpc_pin_model
`default_nettype wire
